// [rtl/bidc_pkg.sv]
// Constants, types and shared arithmetic for the beacon intensity and
// duration controller.
// Assumes a single 125 MHz clock and APB register access.
package bidc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam longint CLK_PERIOD_NS = 8;
  localparam longint SECOND_NS     = 1000000000;
  localparam int     SEC_CYCLES    = int'(SECOND_NS / CLK_PERIOD_NS);
  localparam int     PRESC_W       = 27;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets and field positions.
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LEVEL_OFS  = 8'h08;
  localparam logic [7:0] CMD_OFS    = 8'h0C;

  localparam int DUR_LSB    = 0;
  localparam int STEPS_LSB  = 8;
  localparam int NIGHT_LSB  = 16;
  localparam int COLOUR_LSB = 20;
  localparam int AMB_EN_BIT = 24;
  localparam int BAT_EN_BIT = 25;
  localparam int REMAIN_LSB = 16;
  localparam int BATT_LSB   = 8;
  localparam int DRIVE_LSB  = 16;
  localparam int START_BIT  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Duration codes: 0..55 give 5..60 s, 56..74 give 120..1200 s, 75 is 3600 s.
  localparam logic [6:0]  DUR_CODE_60S  = 7'h37;
  localparam logic [6:0]  DUR_CODE_MAX  = 7'h4B;
  localparam logic [11:0] DUR_MIN_S     = 12'h005;
  localparam logic [11:0] DUR_STEP_S    = 12'h03C;
  localparam logic [11:0] DUR_HOUR_S    = 12'hE10;

  // Reset values.
  localparam logic [6:0]  DUR_CODE_RST  = 7'h0F;
  localparam logic [6:0]  STEPS_RST     = 7'h11;
  localparam logic [3:0]  NIGHT_RST     = 4'hA;
  localparam logic        AMB_EN_RST    = 1'b1;
  localparam logic        BAT_EN_RST    = 1'b1;
  localparam logic [3:0]  AMB_LEVEL_RST = 4'hA;

  // Current limits and steps.
  localparam logic [10:0] STEP_MA       = 11'h014;
  localparam logic [6:0]  STEPS_MAX     = 7'h46;
  localparam logic [10:0] DRIVE_MIN_MA  = 11'h014;
  localparam logic [10:0] DRIVE_MAX_MA  = 11'h578;
  localparam logic [6:0]  PCT_FULL      = 7'h64;
  localparam logic [6:0]  BATT_KNEE_PCT = 7'h46;
  localparam logic [6:0]  TRIM_MIN_PCT  = 7'h5A;
  localparam logic [6:0]  TRIM_MAX_PCT  = 7'h78;
  localparam logic signed [8:0] TEMP_REF_C = 9'sh019;

  typedef enum logic [1:0] {
    BIDC_COL_OFF    = 2'h0,
    BIDC_COL_RED    = 2'h1,
    BIDC_COL_YELLOW = 2'h2
  } bidc_colour_t;

  typedef enum logic [0:0] {
    BIDC_IDLE  = 1'b0,
    BIDC_FLASH = 1'b1
  } bidc_state_t;

  // Scales a current by a percentage.
  function automatic logic [10:0] scale(input logic [10:0] v,
                                        input logic [6:0]  pct);
    logic [19:0] prod;
    prod  = 20'(v) * 20'(pct);
    scale = 11'(prod / 20'd100);
  endfunction : scale

endpackage : bidc_pkg

// [rtl/bidc_calc_if.sv]
// Carries the current setpoint and its scaling factors from the control
// block to the current calculator, and the limited result back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface bidc_calc_if;
  logic [10:0] prog_ma;
  logic [6:0]  night_pct;
  logic [6:0]  amb_pct;
  logic [6:0]  batt_pct;
  logic [6:0]  temp_pct;
  logic        halve;
  logic [10:0] drive_ma;

  modport ctrl (output prog_ma, night_pct, amb_pct, batt_pct, temp_pct,
                output halve, input drive_ma);
  modport calc (input prog_ma, night_pct, amb_pct, batt_pct, temp_pct,
                input halve, output drive_ma);
endinterface : bidc_calc_if
`default_nettype wire

// [rtl/bidc_current_calc.sv]
// Computes the LED driver current command from the programmed current and
// the active scaling factors, then applies bank halving and the limits.
// Assumes factors are stable percentages from the control block.
`timescale 1ns/1ns
`default_nettype none
module bidc_current_calc (
  input  wire logic mclk,
  input  wire logic resetn,
  bidc_calc_if.calc cif
);

  typedef struct packed {
    logic [10:0] drive_ma;
  } bidc_calc_state_t;

  bidc_calc_state_t st_ff;
  bidc_calc_state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [10:0] v;
    v = bidc_pkg::scale(cif.prog_ma, cif.night_pct);
    v = bidc_pkg::scale(v, cif.amb_pct);
    v = bidc_pkg::scale(v, cif.batt_pct);
    v = bidc_pkg::scale(v, cif.temp_pct);
    if (cif.halve) begin
      v = v >> 1;
    end
    if (v > bidc_pkg::DRIVE_MAX_MA) begin
      v = bidc_pkg::DRIVE_MAX_MA;
    end
    if (v < bidc_pkg::DRIVE_MIN_MA) begin
      v = bidc_pkg::DRIVE_MIN_MA;
    end
    nxt_st          = st_ff;
    nxt_st.drive_ma = v;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '{drive_ma: bidc_pkg::DRIVE_MIN_MA};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cif.drive_ma = st_ff.drive_ma;

endmodule : bidc_current_calc
`default_nettype wire

// [rtl/bidc_top.sv]
// Beacon intensity and duration controller: APB configuration, flash
// duration timer, bank gating and scaling factor generation.
// Assumes all pin inputs are synchronous to mclk; flash pattern, day/night
// status, ambient level and battery charge come from neighbouring logic.
`timescale 1ns/1ns
`default_nettype none
module bidc_top #(
  parameter int SEC_CYCLES = bidc_pkg::SEC_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        button_closed,
  input  wire logic        bank_a_req,
  input  wire logic        bank_b_req,
  input  wire logic        rapid_flash_light_bar_pattern,
  input  wire logic        photo_night,
  input  wire logic [3:0]  ambient_meas,
  input  wire logic [6:0]  battery_soc,
  input  wire logic        low_voltage_cutoff,
  input  wire logic [7:0]  led_temp_c,
  output logic             bank_a_on,
  output logic             bank_b_on,
  output logic             flashing,
  output logic      [10:0] drive_ma,
  output logic      [3:0]  ambient_level,
  output logic      [6:0]  battery_dim_pct
);

  // Last prescaler count of one second; the bench shortens the second.
  localparam logic [bidc_pkg::PRESC_W-1:0] PRESC_LAST =
    bidc_pkg::PRESC_W'(SEC_CYCLES - 1);

  typedef struct packed {
    logic [6:0]                  dur_code;
    logic [6:0]                  steps;
    logic [3:0]                  night_tens;
    bidc_pkg::bidc_colour_t      colour;
    logic                        amb_en;
    logic                        bat_en;
    bidc_pkg::bidc_state_t       fsm;
    logic [bidc_pkg::PRESC_W-1:0] presc;
    logic [11:0]                 remain;
    logic [3:0]                  amb_level;
    logic [6:0]                  batt_pct;
    logic                        button_q;
    logic                        bank_a;
    logic                        bank_b;
    logic [31:0]                 rdata;
    logic                        slverr;
  } bidc_state_t;

  bidc_state_t st_ff;
  bidc_state_t nxt_st;

  // The calculator registers its result, one clock behind the factors.
  bidc_calc_if cif ();

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Converts a duration code into seconds: 0..55 count single seconds from
  // five, 56..74 whole minutes from two, and 75 selects the hour.
  function automatic logic [11:0] dur_seconds(input logic [6:0] code);
    if (code <= bidc_pkg::DUR_CODE_60S) begin
      dur_seconds = bidc_pkg::DUR_MIN_S + 12'(code);
    end else if (code < bidc_pkg::DUR_CODE_MAX) begin
      dur_seconds = 12'(12'(code - bidc_pkg::DUR_CODE_60S + 7'h01)
                    * bidc_pkg::DUR_STEP_S);
    end else begin
      dur_seconds = bidc_pkg::DUR_HOUR_S;
    end
  endfunction : dur_seconds

  // Maps ambient level 1..10 onto 50..100 percent.
  function automatic logic [6:0] amb_pct(input logic [3:0] level);
    logic [3:0] l;
    logic [8:0] span;
    l = (level == 4'h0) ? 4'h1 : ((level > 4'hA) ? 4'hA : level);
    // The product reaches 450, so it needs nine bits before the divide.
    span    = 9'(l - 4'h1) * 9'h032;
    amb_pct = 7'h32 + 7'(span / 9'h009);
  endfunction : amb_pct

  // Temperature trim: red LEDs trim twice as hard as yellow ones.
  // Off leaves the current untrimmed.
  function automatic logic [6:0] temp_pct(input bidc_pkg::bidc_colour_t c,
                                          input logic [7:0] t);
    logic signed [8:0] d;
    logic signed [8:0] p;
    d = 9'($signed(t)) - bidc_pkg::TEMP_REF_C;
    case (c)
      bidc_pkg::BIDC_COL_RED:    p = 9'sd100 + (d >>> 2);
      bidc_pkg::BIDC_COL_YELLOW: p = 9'sd100 + (d >>> 3);
      default:                   p = 9'sd100;
    endcase
    if (p < $signed({2'b00, bidc_pkg::TRIM_MIN_PCT})) begin
      temp_pct = bidc_pkg::TRIM_MIN_PCT;
    end else if (p > $signed({2'b00, bidc_pkg::TRIM_MAX_PCT})) begin
      temp_pct = bidc_pkg::TRIM_MAX_PCT;
    end else begin
      temp_pct = 7'(p);
    end
  endfunction : temp_pct

  // Valid colour codes only.
  function automatic logic colour_ok(input logic [1:0] c);
    colour_ok = (c != 2'h3);
  endfunction : colour_ok

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    logic setup;
    logic wr;
    logic start;
    logic [6:0]  f_dur;
    logic [6:0]  f_steps;
    logic [3:0]  f_night;
    logic [1:0]  f_col;
    logic [31:0] rd;
    logic        err;
    rd      = 32'h0000_0000;
    err     = 1'b0;
    setup   = psel & ~penable;
    wr      = psel & penable & pwrite;
    f_dur   = pwdata[bidc_pkg::DUR_LSB +: 7];
    f_steps = pwdata[bidc_pkg::STEPS_LSB +: 7];
    f_night = pwdata[bidc_pkg::NIGHT_LSB +: 4];
    f_col   = pwdata[bidc_pkg::COLOUR_LSB +: 2];
    // Only the press edge or a CMD write of the start bit starts a flash; a held button does not retrigger.
    start   = button_closed & ~st_ff.button_q;
    nxt_st  = st_ff;
    nxt_st.button_q = button_closed;

    // Configuration writes; out-of-range fields keep their old value.
    if (wr && paddr == bidc_pkg::CFG_OFS) begin
      if (f_dur <= bidc_pkg::DUR_CODE_MAX) begin
        nxt_st.dur_code = f_dur;
      end
      if (f_steps != 7'h00 && f_steps <= bidc_pkg::STEPS_MAX) begin
        nxt_st.steps = f_steps;
      end
      if (f_night != 4'h0 && f_night <= 4'hA) begin
        nxt_st.night_tens = f_night;
      end
      if (colour_ok(f_col)) begin
        nxt_st.colour = bidc_pkg::bidc_colour_t'(f_col);
      end
      nxt_st.amb_en = pwdata[bidc_pkg::AMB_EN_BIT];
      nxt_st.bat_en = pwdata[bidc_pkg::BAT_EN_BIT];
    end
    if (wr && paddr == bidc_pkg::CMD_OFS && pwdata[bidc_pkg::START_BIT]) begin
      start = 1'b1;
    end

    // Flash duration timer; a new start restarts the full duration.
    case (st_ff.fsm)
      bidc_pkg::BIDC_IDLE: begin
        if (start) begin
          nxt_st.fsm    = bidc_pkg::BIDC_FLASH;
          nxt_st.remain = dur_seconds(st_ff.dur_code);
          nxt_st.presc  = '0;
        end
      end
      bidc_pkg::BIDC_FLASH: begin
        // Ends at the tick that would take remain from one to zero.
        if (start) begin
          nxt_st.remain = dur_seconds(st_ff.dur_code);
          nxt_st.presc  = '0;
        end else if (st_ff.presc == PRESC_LAST) begin
          nxt_st.presc = '0;
          if (st_ff.remain <= 12'h001) begin
            nxt_st.remain = 12'h000;
            nxt_st.fsm    = bidc_pkg::BIDC_IDLE;
          end else begin
            nxt_st.remain = st_ff.remain - 12'h001;
          end
        end else begin
          nxt_st.presc = st_ff.presc + 1'b1;
        end
      end
      default: begin
        nxt_st.fsm = bidc_pkg::BIDC_IDLE;
      end
    endcase

    // Bank gating: nothing lights outside a flash.
    nxt_st.bank_a = (nxt_st.fsm == bidc_pkg::BIDC_FLASH) & bank_a_req;
    nxt_st.bank_b = (nxt_st.fsm == bidc_pkg::BIDC_FLASH) & bank_b_req;

    // Ambient level follows the sensor only while enabled.
    if (st_ff.amb_en) begin
      nxt_st.amb_level = ambient_meas;
    end

    // Battery dimming percentage.
    if (low_voltage_cutoff) begin
      nxt_st.batt_pct = 7'h00;
    end else if (st_ff.bat_en && battery_soc < bidc_pkg::BATT_KNEE_PCT) begin
      nxt_st.batt_pct = battery_soc;
    end else begin
      nxt_st.batt_pct = bidc_pkg::PCT_FULL;
    end

    // Read data and error are captured in the setup cycle, so prdata comes
    // from a flip-flop and stands through the access phase.
    case (paddr)
      bidc_pkg::CFG_OFS: begin
        rd[bidc_pkg::DUR_LSB +: 7]    = st_ff.dur_code;
        rd[bidc_pkg::STEPS_LSB +: 7]  = st_ff.steps;
        rd[bidc_pkg::NIGHT_LSB +: 4]  = st_ff.night_tens;
        rd[bidc_pkg::COLOUR_LSB +: 2] = st_ff.colour;
        rd[bidc_pkg::AMB_EN_BIT]      = st_ff.amb_en;
        rd[bidc_pkg::BAT_EN_BIT]      = st_ff.bat_en;
      end
      bidc_pkg::STATUS_OFS: begin
        rd[0]                         = st_ff.fsm == bidc_pkg::BIDC_FLASH;
        rd[bidc_pkg::REMAIN_LSB +: 12] = st_ff.remain;
      end
      bidc_pkg::LEVEL_OFS: begin
        rd[3:0]                       = st_ff.amb_level;
        rd[bidc_pkg::BATT_LSB +: 7]   = st_ff.batt_pct;
        rd[bidc_pkg::DRIVE_LSB +: 11] = cif.drive_ma;
      end
      bidc_pkg::CMD_OFS: begin
        rd = 32'h0000_0000;
      end
      default: begin
        err = 1'b1;
      end
    endcase
    if (setup) begin
      nxt_st.rdata  = rd;
      nxt_st.slverr = err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '{dur_code:   bidc_pkg::DUR_CODE_RST,
                 steps:      bidc_pkg::STEPS_RST,
                 night_tens: bidc_pkg::NIGHT_RST,
                 colour:     bidc_pkg::BIDC_COL_RED,
                 amb_en:     bidc_pkg::AMB_EN_RST,
                 bat_en:     bidc_pkg::BAT_EN_RST,
                 fsm:        bidc_pkg::BIDC_IDLE,
                 presc:      '0,
                 remain:     12'h000,
                 amb_level:  bidc_pkg::AMB_LEVEL_RST,
                 batt_pct:   bidc_pkg::PCT_FULL,
                 button_q:   1'b0,
                 bank_a:     1'b0,
                 bank_b:     1'b0,
                 rdata:      32'h0000_0000,
                 slverr:     1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Factors towards the current calculator.
  always_comb begin
    cif.prog_ma = 11'(st_ff.steps * bidc_pkg::STEP_MA);
    if (photo_night) begin
      cif.night_pct = 7'(st_ff.night_tens * 4'hA);
    end else begin
      cif.night_pct = bidc_pkg::PCT_FULL;
    end
    // Ambient scaling shapes daytime intensity only.
    if (st_ff.amb_en && !photo_night) begin
      cif.amb_pct = amb_pct(st_ff.amb_level);
    end else begin
      cif.amb_pct = bidc_pkg::PCT_FULL;
    end
    // The battery factor never reaches zero, so the floor clamp decides.
    if (st_ff.batt_pct == 7'h00) begin
      cif.batt_pct = 7'h01;
    end else begin
      cif.batt_pct = st_ff.batt_pct;
    end
    cif.temp_pct = temp_pct(st_ff.colour, led_temp_c);
    // Only one bank of a rapid pattern lit means half the current.
    cif.halve    = rapid_flash_light_bar_pattern
                   & (bank_a_req ^ bank_b_req);
  end

  bidc_current_calc u_calc (
    .mclk   (mclk),
    .resetn (resetn),
    .cif    (cif.calc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  // Zero wait states: every access phase completes in its first cycle.
  assign pready          = psel & penable;
  assign prdata          = st_ff.rdata;
  assign pslverr         = st_ff.slverr & psel & penable;
  assign flashing        = st_ff.fsm == bidc_pkg::BIDC_FLASH;
  // Cutoff darkens both banks at once, without waiting for a clock.
  assign bank_a_on       = st_ff.bank_a & ~low_voltage_cutoff;
  assign bank_b_on       = st_ff.bank_b & ~low_voltage_cutoff;
  assign drive_ma        = cif.drive_ma;
  assign ambient_level   = st_ff.amb_level;
  assign battery_dim_pct = st_ff.batt_pct;

endmodule : bidc_top
`default_nettype wire

// [tb/bidc_assertions.sv]
// Concurrent checks on the beacon controller's output pins.
// Assumes it is bound to bidc_top and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module bidc_chk (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        button_closed,
  input wire logic        low_voltage_cutoff,
  input wire logic [6:0]  battery_soc,
  input wire logic [3:0]  ambient_meas,
  input wire logic        flashing,
  input wire logic        bank_a_on,
  input wire logic        bank_b_on,
  input wire logic [10:0] drive_ma,
  input wire logic [3:0]  ambient_level,
  input wire logic [6:0]  battery_dim_pct
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  AST_DRIVE_MAX: assert property (drive_ma <= 11'h578)
    else $error("drive current above ceiling");
  AST_DRIVE_MIN: assert property (drive_ma >= 11'h014)
    else $error("drive current below floor");
  AST_IDLE_DARK: assert property (!flashing |-> !bank_a_on && !bank_b_on)
    else $error("bank lit outside a flash");
  AST_BTN_START: assert property ($rose(button_closed) |=> flashing)
    else $error("button closure did not start a flash");
  AST_FLASH_MIN: assert property ($rose(flashing) |-> flashing [*8])
    else $error("flash ended far too early");
  AST_AMB_TRACK: assert property (
    $changed(ambient_level) |-> ambient_level == $past(ambient_meas))
    else $error("ambient level moved to an unmeasured value");
  AST_BATT_FULL: assert property (
    !low_voltage_cutoff && battery_soc >= 7'h46 |=> battery_dim_pct == 7'h64)
    else $error("battery dimming above knee");
  AST_BATT_DIM: assert property (
    !low_voltage_cutoff && battery_soc < 7'h46
    |=> battery_dim_pct == $past(battery_soc) || battery_dim_pct == 7'h64)
    else $error("battery dimming not the charge figure");
  AST_CUTOFF: assert property (
    low_voltage_cutoff
    |=> battery_dim_pct == 7'h00 && !bank_a_on && !bank_b_on)
    else $error("cutoff did not stop the fixtures");
endmodule : bidc_chk

bind bidc_top bidc_chk u_chk (
  .mclk(mclk), .resetn(resetn), .button_closed(button_closed),
  .low_voltage_cutoff(low_voltage_cutoff), .battery_soc(battery_soc),
  .ambient_meas(ambient_meas), .flashing(flashing), .bank_a_on(bank_a_on),
  .bank_b_on(bank_b_on), .drive_ma(drive_ma), .ambient_level(ambient_level),
  .battery_dim_pct(battery_dim_pct));
`default_nettype wire

// [tb/bidc_led_driver_model.sv]
// Behavioural LED driver: splits the commanded current over lit banks.
// Assumes one driver feeding two banks of fixtures.
`timescale 1ns/1ns
`default_nettype none
module bidc_led_driver_model (
  input  wire logic        bank_a_on,
  input  wire logic        bank_b_on,
  input  wire logic [10:0] drive_ma,
  output logic      [10:0] bank_ma
);
  // Current per lit bank; nothing flows when both banks are dark.
  always_comb begin
    if (bank_a_on && bank_b_on) begin
      bank_ma = drive_ma >> 1;
    end else if (bank_a_on || bank_b_on) begin
      bank_ma = drive_ma;
    end else begin
      bank_ma = 11'h000;
    end
  end
endmodule : bidc_led_driver_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the beacon controller over APB and its pins.
// Assumes a shortened second of 10 clock cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int SC = 10;
  logic        mclk, resetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic        button_closed, bank_a_req, bank_b_req, rapid, photo_night;
  logic [3:0]  ambient_meas, ambient_level;
  logic [6:0]  battery_soc, battery_dim_pct;
  logic        low_voltage_cutoff, bank_a_on, bank_b_on, flashing;
  logic [7:0]  led_temp_c;
  logic [10:0] drive_ma, bank_ma;
  int          mismatches, n_tests;

  bidc_top #(.SEC_CYCLES(SC)) u_dut (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .button_closed(button_closed),
    .bank_a_req(bank_a_req), .bank_b_req(bank_b_req),
    .rapid_flash_light_bar_pattern(rapid), .photo_night(photo_night),
    .ambient_meas(ambient_meas), .battery_soc(battery_soc),
    .low_voltage_cutoff(low_voltage_cutoff), .led_temp_c(led_temp_c),
    .bank_a_on(bank_a_on), .bank_b_on(bank_b_on), .flashing(flashing),
    .drive_ma(drive_ma), .ambient_level(ambient_level),
    .battery_dim_pct(battery_dim_pct));

  bidc_led_driver_model u_drv (.bank_a_on(bank_a_on), .bank_b_on(bank_b_on),
    .drive_ma(drive_ma), .bank_ma(bank_ma));

  always #4 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("mismatches %0d of %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  function automatic logic [31:0] cfg(logic [6:0] d, logic [6:0] s,
      logic [3:0] nt, logic [1:0] c, logic a, logic b);
    return {6'h00, b, a, 2'h0, c, nt, 1'b0, s, 1'b0, d};
  endfunction : cfg

  // Sets config and pins, lets the pipeline settle, checks the current.
  task automatic cur(input logic [31:0] c, input logic pn, input logic [3:0] am,
      input logic [6:0] soc, input logic [7:0] t, input logic [2:0] bk,
      input logic [10:0] exp);
    apb(1'b1, bidc_pkg::CFG_OFS, c);
    photo_night  <= pn;
    ambient_meas <= am;
    battery_soc  <= soc;
    led_temp_c   <= t;
    {rapid, bank_a_req, bank_b_req} <= bk;
    repeat (4) @(posedge mclk);
    chk(32'(drive_ma), 32'(exp));
  endtask : cur

  // Starts a flash and measures how many cycles it stays lit.
  task automatic flash(input logic [6:0] code, input int secs, input logic btn);
    int n;
    apb(1'b1, bidc_pkg::CFG_OFS, cfg(code, 7'h11, 4'hA, 2'h0, 1'b1, 1'b1));
    if (btn) begin
      button_closed <= 1'b1;
      @(posedge mclk);
      button_closed <= 1'b0;
    end else begin
      apb(1'b1, bidc_pkg::CMD_OFS, 32'h0000_0001);
    end
    n = 0;
    while (flashing !== 1'b1 && n < 5) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    chk(32'(bank_a_on), 32'h1);
    chk(32'(bank_ma), 32'd170);
    n = 1;
    while (flashing === 1'b1 && n < 40000) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n >= secs * SC - 1 && n <= secs * SC + 2), 32'h1);
    chk(32'({bank_a_on, bank_b_on}), 32'h0);
  endtask : flash

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 90000);
    mismatches++;
    end_of_test();
  end

  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {button_closed, rapid, photo_night, low_voltage_cutoff} = '0;
    {bank_a_req, bank_b_req} = 2'h3;
    ambient_meas = 4'hA;
    battery_soc = 7'h64;
    led_temp_c = 8'h19;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    apb(1'b0, bidc_pkg::CFG_OFS, 32'h0);
    chk(rd, 32'h031A_110F);
    chk(32'(drive_ma), 32'd340);
    chk(32'({ambient_level, battery_dim_pct}), {21'h0, 4'hA, 7'h64});
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(err), 32'h1);
    cur(cfg(7'h0F, 7'h11, 4'hA, 2'h1, 1'b1, 1'b1),
        1'b0, 4'hA, 7'h64, 8'h19, 3'h3, 11'h154);
    cur(cfg(7'h0F, 7'h11, 4'hA, 2'h0, 1'b1, 1'b1),
        1'b0, 4'hA, 7'h64, 8'h19, 3'h6, 11'h0AA);
    cur(cfg(7'h0F, 7'h11, 4'hA, 2'h0, 1'b1, 1'b1),
        1'b0, 4'hA, 7'h64, 8'h19, 3'h7, 11'h154);
    cur(cfg(7'h0F, 7'h32, 4'hA, 2'h1, 1'b1, 1'b1),
        1'b0, 4'hA, 7'h64, 8'h2D, 3'h3, 11'h41A);
    cur(cfg(7'h0F, 7'h32, 4'hA, 2'h2, 1'b1, 1'b1),
        1'b0, 4'hA, 7'h64, 8'h2D, 3'h3, 11'h3FC);
    cur(cfg(7'h0F, 7'h32, 4'hA, 2'h0, 1'b1, 1'b1),
        1'b0, 4'hA, 7'h64, 8'h2D, 3'h3, 11'h3E8);
    cur(cfg(7'h0F, 7'h46, 4'hA, 2'h1, 1'b1, 1'b1),
        1'b0, 4'hA, 7'h64, 8'h2D, 3'h3, 11'h578);
    cur(cfg(7'h0F, 7'h32, 4'h5, 2'h0, 1'b1, 1'b1),
        1'b1, 4'hA, 7'h64, 8'h19, 3'h3, 11'h1F4);
    cur(cfg(7'h0F, 7'h01, 4'h1, 2'h0, 1'b1, 1'b1),
        1'b1, 4'hA, 7'h64, 8'h19, 3'h3, 11'h014);
    cur(cfg(7'h0F, 7'h32, 4'hA, 2'h0, 1'b1, 1'b1),
        1'b0, 4'h1, 7'h64, 8'h19, 3'h3, 11'h1F4);
    chk(32'(ambient_level), 32'h1);
    cur(cfg(7'h0F, 7'h32, 4'hA, 2'h0, 1'b0, 1'b1),
        1'b0, 4'h7, 7'h64, 8'h19, 3'h3, 11'h3E8);
    chk(32'(ambient_level), 32'h1);
    cur(cfg(7'h0F, 7'h32, 4'hA, 2'h0, 1'b1, 1'b1),
        1'b0, 4'hA, 7'h3C, 8'h19, 3'h3, 11'h258);
    chk(32'(battery_dim_pct), 32'd60);
    cur(cfg(7'h0F, 7'h32, 4'hA, 2'h0, 1'b1, 1'b0),
        1'b0, 4'hA, 7'h3C, 8'h19, 3'h3, 11'h3E8);
    apb(1'b1, bidc_pkg::CFG_OFS, cfg(7'h0F, 7'h00, 4'hA, 2'h0, 1'b1, 1'b1));
    apb(1'b1, bidc_pkg::CFG_OFS, cfg(7'h4C, 7'h47, 4'hA, 2'h0, 1'b1, 1'b1));
    apb(1'b0, bidc_pkg::CFG_OFS, 32'h0);
    chk(rd, cfg(7'h0F, 7'h32, 4'hA, 2'h0, 1'b1, 1'b1));
    low_voltage_cutoff <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(32'({drive_ma, battery_dim_pct}), {14'h0, 11'd20, 7'h00});
    low_voltage_cutoff <= 1'b0;
    battery_soc <= 7'h64;
    flash(7'h00, 5, 1'b1);
    flash(7'h37, 60, 1'b0);
    flash(7'h38, 120, 1'b0);
    flash(7'h4A, 1200, 1'b0);
    flash(7'h4B, 3600, 1'b0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
